/* logic/liu_serial_host_port.v */
`timescale 1ns/1ps
`include "liu_serial_map.vh"

module liu_serial_host_port (
	input  wire       clk,
	input  wire       rst_n,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr_en,
	input  wire       rd_en,
	output reg  [7:0] rdata,
	output reg        shift_clk,
	output reg        shift_out,
	input  wire       shift_in,
	output reg        target_select_a_n,
	output reg        target_select_b_n,
	output reg        shared_irq_n
);

	localparam [1:0] ST_IDLE  = 2'b00;
	localparam [1:0] ST_SHIFT = 2'b01;
	localparam [1:0] ST_PUSH  = 2'b10;
	// rate counts cut to the counter width
	localparam integer HALF_SLOW_I = `HALF_SLOW;
	localparam integer HALF_FAST_I = `HALF_FAST;
	localparam [6:0] HALF_SLOW = HALF_SLOW_I[6:0];
	localparam [6:0] HALF_FAST = HALF_FAST_I[6:0];
	localparam [4:0] FRAME_BITS = `FRAME_BITS;
	localparam [4:0] CMD_BITS = `CMD_BITS;

	// register file
	reg  [7:0]  serial_command_reg;
	reg  [7:0]  serial_byte_reg;
	reg         transfer_complete_flag;
	reg         target_select_bit;
	reg         shift_rate_select;
	reg         completion_irq_enable;

	// engine
	reg  [1:0]  state;
	reg  [6:0]  half_cnt;
	reg  [4:0]  bit_cnt;
	reg  [15:0] tx_shift;
	reg  [7:0]  rx_shift;
	reg         op_read;
	reg         rate_latched;
	reg         in_meta;
	reg         in_sync;

	// two-entry receive buffer
	reg  [7:0]  buf_data [0:1];
	reg         wr_ptr;
	reg         rd_ptr;
	reg  [1:0]  buf_count;

	wire        hit_cmd;
	wire        hit_data;
	wire        hit_status;
	wire        hit_cfg;
	wire        start;
	wire        half_done;
	wire        in_valid;
	wire        in_ready;
	wire        out_valid;
	wire        out_ready;
	wire        push;
	wire        pop;
	wire        finish;
	wire [6:0]  half_limit;
	wire        op_direction_bit;
	wire [6:0]  remote_reg_address;

	assign hit_cmd    = (addr == `OFS_SERIAL_COMMAND);
	assign hit_data   = (addr == `OFS_SERIAL_DATA);
	assign hit_status = (addr == `OFS_SERIAL_STATUS);
	assign hit_cfg    = (addr == `OFS_SERIAL_CONFIGURATION);

	// R05: direction in bit zero
	assign op_direction_bit = serial_command_reg[`BIT_OP_DIRECTION];
	// R06: remote address above it
	assign remote_reg_address = serial_command_reg[7:1];

	// R01: command write starts transfer
	assign start = wr_en && hit_cmd && (state == ST_IDLE);

	// R12: rate select per transfer
	assign half_limit = rate_latched ? HALF_FAST : HALF_SLOW;
	assign half_done  = (half_cnt == half_limit - 7'h01);

	// buffer handshake
	assign in_valid  = (state == ST_PUSH) && op_read;
	assign in_ready  = (buf_count != 2'b10);
	assign push      = in_valid && in_ready;
	assign out_valid = (buf_count != 2'b00);
	assign out_ready = !(wr_en && hit_data);
	assign pop       = out_valid && out_ready;
	assign finish    = (state == ST_PUSH) && (!op_read || in_ready);

	// pin synchroniser
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_meta <= 1'b0;
			in_sync <= 1'b0;
		end else begin
			in_meta <= shift_in;
			in_sync <= in_meta;
		end
	end

	// command and configuration registers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_command_reg    <= `RST_SERIAL_COMMAND;
			target_select_bit     <= 1'b0;
			shift_rate_select     <= 1'b0;
			completion_irq_enable <= 1'b0;
		end else begin
			if (start) begin
				serial_command_reg <= wdata;
			end
			// R13: reserved bits are not stored
			if (wr_en && hit_cfg) begin
				target_select_bit     <= wdata[`BIT_TARGET_SELECT];
				shift_rate_select     <= wdata[`BIT_SHIFT_RATE_SELECT];
				completion_irq_enable <= wdata[`BIT_COMPLETION_IRQ_EN];
			end
		end
	end

	// data register: processor write or buffer drain
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_byte_reg <= `RST_SERIAL_DATA;
		end else if (wr_en && hit_data) begin
			serial_byte_reg <= wdata;
		end else if (pop) begin
			// R03: returned byte lands here
			serial_byte_reg <= buf_data[rd_ptr];
		end
	end

	// buffer entries
	genvar gi;
	generate
		for (gi = 0; gi < `BUF_DEPTH; gi = gi + 1) begin : g_entry
			// entry written when the pointer names it
			wire entry_hit;
			assign entry_hit = push && ({31'h00000000, wr_ptr} == gi);
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					buf_data[gi] <= 8'h00;
				end else if (entry_hit) begin
					buf_data[gi] <= rx_shift;
				end
			end
		end
	endgenerate

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr    <= 1'b0;
			rd_ptr    <= 1'b0;
			buf_count <= 2'b00;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			if (push && !pop) begin
				buf_count <= buf_count + 2'b01;
			end else if (pop && !push) begin
				buf_count <= buf_count - 2'b01;
			end
		end
	end

	// completion flag
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transfer_complete_flag <= 1'b0;
		end else if (finish) begin
			// R08: set on finish, wins over clear
			transfer_complete_flag <= 1'b1;
		end else if (start) begin
			// R07: held low while running
			transfer_complete_flag <= 1'b0;
		end else if (rd_en && hit_status) begin
			// R09: read clears flag
			transfer_complete_flag <= 1'b0;
		end
	end

	// shift engine
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state        <= ST_IDLE;
			half_cnt     <= 7'h00;
			bit_cnt      <= 5'h00;
			tx_shift     <= 16'h0000;
			rx_shift     <= 8'h00;
			op_read      <= 1'b0;
			rate_latched <= 1'b0;
			shift_clk    <= 1'b0;
			shift_out    <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					// R15: clock parked low
					shift_clk <= 1'b0;
					half_cnt  <= 7'h00;
					bit_cnt   <= 5'h00;
					if (start) begin
						// R02: command then data, lsb first
						tx_shift     <= {serial_byte_reg, wdata};
						// R04: direction bit leads the frame
						shift_out    <= wdata[`BIT_OP_DIRECTION];
						op_read      <= wdata[`BIT_OP_DIRECTION];
						// R12: rate held for the frame
						rate_latched <= shift_rate_select;
						state        <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (half_done) begin
						half_cnt  <= 7'h00;
						shift_clk <= ~shift_clk;
						if (!shift_clk) begin
							// R03: sample returned bits lsb first
							if (op_read && (bit_cnt >= CMD_BITS)) begin
								rx_shift <= {in_sync, rx_shift[7:1]};
							end
						end else begin
							bit_cnt  <= bit_cnt + 5'h01;
							tx_shift <= {1'b0, tx_shift[15:1]};
							shift_out <= tx_shift[1];
							// R03: read frame drives only the command
							if (op_read && (bit_cnt >= CMD_BITS - 5'h01)) begin
								shift_out <= 1'b0;
							end
							if (bit_cnt == FRAME_BITS - 5'h01) begin
								shift_out <= 1'b0;
								state     <= ST_PUSH;
							end
						end
					end else begin
						half_cnt <= half_cnt + 7'h01;
					end
				end
				ST_PUSH: begin
					shift_clk <= 1'b0;
					if (finish) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state     <= ST_IDLE;
					shift_clk <= 1'b0;
				end
			endcase
		end
	end

	// chip selects and interrupt
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			target_select_a_n <= 1'b1;
			target_select_b_n <= 1'b1;
			shared_irq_n      <= 1'b1;
		end else begin
			// R11: select bit steers which line lowers
			// R15: both high while idle
			target_select_a_n <= !((state != ST_IDLE) && !target_select_bit);
			target_select_b_n <= !((state != ST_IDLE) && target_select_bit);
			// R10: request follows flag and enable
			shared_irq_n <= !(transfer_complete_flag && completion_irq_enable);
		end
	end

	// read port
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (rd_en) begin
			if (hit_cmd) begin
				rdata <= {remote_reg_address, op_direction_bit};
			end else if (hit_data) begin
				rdata <= serial_byte_reg;
			end else if (hit_status) begin
				rdata <= {7'h00, transfer_complete_flag};
			end else if (hit_cfg) begin
				rdata <= {target_select_bit, shift_rate_select, 5'h00,
					completion_irq_enable};
			end else begin
				rdata <= 8'h00;
			end
		end
	end

endmodule

/* logic/liu_serial_map.vh */
// Contract
// R01: command write starts one serial transfer
// R02: write shifts command byte then data byte
// R03: read shifts command, captures returned byte
// R04: direction bit first, bytes lsb first
// R05: command bit 0: zero write, one read
// R06: command bits 7..1 carry remote address
// R07: completion flag zero while transfer runs
// R08: finish sets flag, irq if enabled
// R09: status read clears completion flag afterwards
// R10: cleared flag withdraws interrupt request
// R11: select bit picks which chip select lowers
// R12: rate bit picks slow or fast clock
// R13: software writes zero to reserved bits
// R14: software waits for completion before restart
// R15: selects high, clock still when idle
`ifndef LIU_SERIAL_MAP_VH
`define LIU_SERIAL_MAP_VH

// register offsets
`define OFS_SERIAL_COMMAND       8'h22
`define OFS_SERIAL_DATA          8'h23
`define OFS_SERIAL_STATUS        8'h24
`define OFS_SERIAL_CONFIGURATION 8'h25

// field positions
`define BIT_OP_DIRECTION         0
`define BIT_TRANSFER_COMPLETE    0
`define BIT_COMPLETION_IRQ_EN    0
`define BIT_SHIFT_RATE_SELECT    6
`define BIT_TARGET_SELECT        7

// reset values (none documented)
`define RST_SERIAL_COMMAND       8'h00
`define RST_SERIAL_DATA          8'h00
`define RST_SERIAL_CONFIGURATION 8'h00

// timing: rates in kHz, half periods rounded up so the rate is never exceeded
`define CLK_KHZ                  125000
`define SLOW_RATE_KHZ            1020
`define FAST_RATE_KHZ            8190
`define HALF_SLOW ((`CLK_KHZ + 2 * `SLOW_RATE_KHZ - 1) / (2 * `SLOW_RATE_KHZ))
`define HALF_FAST ((`CLK_KHZ + 2 * `FAST_RATE_KHZ - 1) / (2 * `FAST_RATE_KHZ))

// frame shape
`define FRAME_BITS               5'h10
`define CMD_BITS                 5'h08
`define BUF_DEPTH                2

`endif

/* test/liu_serial_asserts.sv */
`timescale 1ns/1ps
module liu_serial_asserts (
	input wire       clk,
	input wire       rst_n,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire       wr_en,
	input wire       rd_en,
	input wire [7:0] rdata,
	input wire       shift_clk,
	input wire       shift_out,
	input wire       shift_in,
	input wire       target_select_a_n,
	input wire       target_select_b_n,
	input wire       shared_irq_n
);
	reg  fast;
	reg  selb;
	reg  ier;
	wire idle = target_select_a_n && target_select_b_n;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fast <= 1'b0;
			selb <= 1'b0;
			ier  <= 1'b0;
		end else if (wr_en && addr == 8'h25) begin
			fast <= wdata[6];
			selb <= wdata[7];
			ier  <= wdata[0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_one_select: assert property (!idle |-> target_select_a_n != target_select_b_n)
		else $error("both selects low");
	a_right_select: assert property (!idle |-> target_select_a_n == selb)
		else $error("wrong select");
	a_start_frame: assert property (wr_en && addr == 8'h22 && idle
		|=> ##1 (!idle && shift_out == $past(wdata[0], 2)))
		else $error("bad frame start");
	a_idle_clock: assert property (idle |-> !shift_clk)
		else $error("clock moves while idle");
	a_fast_half: assert property ($rose(shift_clk) && fast |-> shift_clk[*8] ##1 !shift_clk)
		else $error("fast half period");
	a_slow_half: assert property ($rose(shift_clk) && !fast |-> ##61 shift_clk ##1 !shift_clk)
		else $error("slow half period");
	a_irq_needs_en: assert property (!shared_irq_n |-> $past(ier))
		else $error("irq while disabled");
	a_irq_withdraw: assert property (rd_en && addr == 8'h24 |-> ##2 shared_irq_n)
		else $error("irq kept after status read");
	a_busy_no_irq: assert property (!shared_irq_n |-> idle || $past(idle, 2))
		else $error("irq during transfer");
endmodule

/* test/liu_model.sv */
`timescale 1ns/1ps
module liu_model (
	input  wire        shift_clk,
	input  wire        shift_out,
	input  wire        sel_n,
	input  wire [7:0]  reply,
	output reg         shift_in,
	output reg  [15:0] frame
);
	integer cnt;
	initial begin
		shift_in = 1'b0;
		frame = 16'h0000;
		cnt = 0;
	end
	// frame capture, count cleared on release
	always @(posedge shift_clk or posedge sel_n) begin
		if (sel_n) begin
			cnt <= 0;
		end else begin
			frame <= {shift_out, frame[15:1]};
			cnt <= cnt + 1;
		end
	end
	// reply lsb first, released line shows the inverse
	always @(negedge shift_clk or posedge sel_n) begin
		if (sel_n)
			shift_in <= ~shift_in;
		else if (cnt >= 8 && cnt < 16)
			shift_in <= reply[cnt - 8];
	end
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_top;
	reg         clk        = 1'b0;
	reg         rst_n      = 1'b0;
	reg  [7:0]  addr       = 8'h00;
	reg  [7:0]  wdata      = 8'h00;
	reg         wr_en      = 1'b0;
	reg         rd_en      = 1'b0;
	reg  [7:0]  reply      = 8'hA5;
	reg  [7:0]  d;
	integer     err_count  = 0;
	integer     n_compared = 0;
	integer     i;
	wire [7:0]  rdata;
	wire        shift_clk;
	wire        shift_out;
	wire        shift_in;
	wire        target_select_a_n;
	wire        target_select_b_n;
	wire        shared_irq_n;
	wire [15:0] frame;
	always #4 clk = ~clk;
	liu_serial_host_port DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .shift_clk(shift_clk),
		.shift_out(shift_out), .shift_in(shift_in), .target_select_a_n(target_select_a_n),
		.target_select_b_n(target_select_b_n), .shared_irq_n(shared_irq_n));
	liu_model u_liu (.shift_clk(shift_clk), .shift_out(shift_out), .reply(reply),
		.sel_n(target_select_a_n & target_select_b_n), .shift_in(shift_in), .frame(frame));
	task wr(input [7:0] a, input [7:0] v);
		@(negedge clk) begin addr = a; wdata = v; wr_en = 1'b1; end
		@(negedge clk) wr_en = 1'b0;
	endtask
	task rd(input [7:0] a, output [7:0] v);
		@(negedge clk) begin addr = a; rd_en = 1'b1; end
		@(negedge clk) rd_en = 1'b0;
		v = rdata;
	endtask
	task stop_test;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		stop_test;
	end
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		wr(8'h25, 8'hC1);
		rd(8'h25, d);
		`CHK(d, 8'hC1)
		wr(8'h23, 8'h5A);
		wr(8'h22, 8'h34);
		for (i = 0; i < 1000 && shared_irq_n; i++) @(negedge clk);
		`CHK(shared_irq_n, 1'b0)
		`CHK(frame, 16'h5A34)
		wr(8'h22, 8'h35);
		rd(8'h24, d);
		`CHK(d, 8'h00)
		`CHK(shared_irq_n, 1'b1)
		for (i = 0; i < 1000 && shared_irq_n; i++) @(negedge clk);
		`CHK(shared_irq_n, 1'b0)
		rd(8'h24, d);
		`CHK(d, 8'h01)
		rd(8'h24, d);
		`CHK(d, 8'h00)
		`CHK(shared_irq_n, 1'b1)
		`CHK(frame, 16'h0035)
		rd(8'h23, d);
		`CHK(d, 8'hA5)
		rd(8'h30, d);
		`CHK(d, 8'h00)
		wr(8'h25, 8'h00);
		reply = 8'h3C;
		wr(8'h22, 8'hB5);
		rd(8'h24, d);
		`CHK(d, 8'h00)
		for (i = 0; i < 2000 && d !== 8'h01; i++) rd(8'h24, d);
		`CHK(d, 8'h01)
		`CHK(shared_irq_n, 1'b1)
		`CHK(frame, 16'h00B5)
		rd(8'h23, d);
		`CHK(d, 8'h3C)
		rd(8'h22, d);
		`CHK(d, 8'hB5)
		stop_test;
	end
endmodule
bind liu_serial_host_port liu_serial_asserts u_chk (.clk(clk), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .shift_clk(shift_clk),
	.shift_out(shift_out), .shift_in(shift_in), .target_select_a_n(target_select_a_n),
	.target_select_b_n(target_select_b_n), .shared_irq_n(shared_irq_n));
